//--- design/pmic_map.vh
`ifndef PMIC_MAP_VH
`define PMIC_MAP_VH

// ==========================================
// Register offsets
`define PMIC_ADDR_PWR 4'h0
`define PMIC_ADDR_IRQ_EN 4'h1
`define PMIC_ADDR_PRIO_LOW 4'h2
`define PMIC_ADDR_EXT_CTRL 4'h3
`define PMIC_ADDR_TRIG 4'h4
`define PMIC_ADDR_FLAGS 4'h5
`define PMIC_ADDR_EVT_STAT 4'h6
`define PMIC_ADDR_EVT_EN 4'h7
`define PMIC_ADDR_EVT_CLR 4'h8
`define PMIC_ADDR_STATE 4'h9

// ==========================================
// Field positions
`define PMIC_PWR_IDLE 0
`define PMIC_PWR_DOWN 1
`define PMIC_EN_GLOBAL 7
`define PMIC_XI_IT2 0
`define PMIC_XI_IE2 1
`define PMIC_XI_EX2 2
`define PMIC_XI_PX2 3
`define PMIC_XI_IT3 4
`define PMIC_XI_IE3 5
`define PMIC_XI_EX3 6
`define PMIC_XI_PX3 7
`define PMIC_FL_EXT0 0
`define PMIC_FL_T0 1
`define PMIC_FL_EXT1 2
`define PMIC_FL_T1 3
`define PMIC_FL_RX 4
`define PMIC_FL_TX 5
`define PMIC_FL_T2 6
`define PMIC_EVT_IDLE_WAKE 0
`define PMIC_EVT_PD_WAKE 1
`define PMIC_EVT_RESET 2
`define PMIC_EVT_VECTOR 3

// ==========================================
// Reset values, vector base and timing
`define PMIC_RESET_BYTE 8'h00
`define PMIC_RESET_PC 16'h0000
`define PMIC_VEC_BASE 16'h0003
`define PMIC_RST_MIN_CLKS 5'd24

`endif

//--- design/pmic_rst_filter.v
`include "pmic_map.vh"

module pmic_rst_filter (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Reset pin
  input wire pin_i,
  // Qualified reset
  output wire valid_o
);

  reg [4:0] cnt_r;
  reg valid_r;

  // ==========================================
  // High-time qualification
  // RULE_04: 24 consecutive highs
  always @(posedge clk_i) begin
    if (reset_i || !pin_i) begin
      cnt_r <= 5'h00;
      valid_r <= 1'b0;
    end else if (cnt_r == `PMIC_RST_MIN_CLKS - 5'h01) begin
      valid_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  assign valid_o = valid_r;

endmodule // pmic_rst_filter

//--- design/pmic_core.v
// What this block does
// RULE_01: Idle bit set enters idle after instruction
// RULE_02: Idle stops only the CPU clock
// RULE_03: Enabled interrupt clears idle bit, wakes
// RULE_04: Reset pin needs 24 high clocks
// RULE_05: Reset loads PC zero, registers default
// RULE_06: Power-down bit stops all clocks, pins hold
// RULE_07: Reset pin ends power-down, restarts at zero
// RULE_08: Watchdog cannot end power-down
// RULE_09: Level-mode enabled external pin wakes power-down
// RULE_10: Woken external source then gets serviced
// RULE_11: Each source has own priority bit
// RULE_12: Preempt only by strictly higher priority
// RULE_13: Higher level wins simultaneous requests
// RULE_14: Fixed polling order for same level
// RULE_15: Eight fixed vector addresses
// RULE_16: Rank external0 first, external3 last
// RULE_17: Only external sources wake power-down
// RULE_18: Hardware clears external and timer0/1 flags
`include "pmic_map.vh"

module pmic_core (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Register port
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [7:0] rdata_o,
  // CPU side
  input wire instr_end_i,
  input wire irq_ack_i,
  input wire reti_i,
  output wire irq_req_o,
  output wire [15:0] irq_vector_o,
  output wire cpu_clk_en_o,
  output wire periph_clk_en_o,
  output wire ports_hold_o,
  output wire cpu_reset_o,
  output wire [15:0] reset_pc_o,
  // Reset sources
  input wire ext_rst_i,
  input wire wdt_rst_i,
  // Interrupt sources
  input wire [3:0] ext_n_i,
  input wire timer0_ovf_i,
  input wire timer1_ovf_i,
  input wire timer2_ovf_i,
  input wire serial_rx_i,
  input wire serial_tx_i,
  // Event interrupt
  output wire irq_o
);

  localparam [2:0] ST_RUN = 3'h1;
  localparam [2:0] ST_IDLE = 3'h2;
  localparam [2:0] ST_PD = 3'h4;

  // ==========================================
  // Helpers
  // Lowest set bit wins: index 0 is ranked highest
  function [3:0] pmic_first;
    input [7:0] req;
    integer k;
    begin
      pmic_first = 4'h0;
      for (k = 7; k >= 0; k = k - 1) begin
        if (req[k]) begin
          pmic_first = {1'b1, k[2:0]};
        end
      end
    end
  endfunction

  function [15:0] pmic_vector;
    input [2:0] idx;
    begin
      pmic_vector = `PMIC_VEC_BASE | {10'h000, idx, 3'h0};
    end
  endfunction

  // ==========================================
  // State
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] power_control_reg;
  reg [7:0] irq_en_r;
  reg [7:0] priority_low_reg;
  reg [7:0] extra_ext_irq_control;
  reg [1:0] trig_r;
  reg [6:0] flags_r;
  reg [6:0] flags_nxt;
  reg [3:0] ext_flag_r;
  reg [3:0] ext_prev_r;
  reg [3:0] evt_stat_r;
  reg [3:0] evt_en_r;
  reg [1:0] in_srv_r;
  reg req_r;
  reg sel_lvl_r;
  reg [2:0] sel_idx_r;
  reg [15:0] vector_r;
  reg [7:0] rdata_r;
  reg cpu_reset_r;
  reg [3:0] evt_set;

  wire rst_valid;
  wire sys_rst;
  wire [3:0] trig;
  wire [3:0] ext_ack;
  wire [3:0] ext_flag_nxt;
  wire [7:0] pend;
  wire [7:0] enab;
  wire [7:0] prio;
  wire [7:0] cand;
  wire [3:0] pick_hi;
  wire [3:0] pick_lo;
  wire use_hi;
  wire use_lo;
  wire sel_valid;
  wire [2:0] sel_idx;
  wire pd_wake;
  wire ack_ok;

  pmic_rst_filter u_rst_filter (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(ext_rst_i),
    .valid_o(rst_valid)
  );

  // ==========================================
  // Reset sources
  // RULE_08: watchdog masked in power-down
  assign sys_rst = reset_i | rst_valid | (wdt_rst_i & ~state_r[2]);

  // ==========================================
  // External pins
  assign trig = {extra_ext_irq_control[`PMIC_XI_IT3], extra_ext_irq_control[`PMIC_XI_IT2],
                 trig_r};
  assign ack_ok = irq_ack_i & req_r;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ext
      // Source index in ranking order: 0, 2, 6, 7
      localparam [2:0] SRC = (g == 0) ? 3'h0 : (g == 1) ? 3'h2 : (g == 2) ? 3'h6 : 3'h7;
      // RULE_18: cleared when vectored
      assign ext_ack[g] = ack_ok & (sel_idx_r == SRC);
      // Level mode follows the pin; edge mode latches a falling edge
      assign ext_flag_nxt[g] = !trig[g] ? ~ext_n_i[g] :
                               ((ext_prev_r[g] & ~ext_n_i[g]) | (ext_flag_r[g] & ~ext_ack[g]));
    end
  endgenerate

  // ==========================================
  // Arbitration
  assign pend = {ext_flag_r[3], ext_flag_r[2], flags_r[`PMIC_FL_T2],
                 flags_r[`PMIC_FL_RX] | flags_r[`PMIC_FL_TX], flags_r[`PMIC_FL_T1],
                 ext_flag_r[1], flags_r[`PMIC_FL_T0], ext_flag_r[0]};
  assign enab = {extra_ext_irq_control[`PMIC_XI_EX3], extra_ext_irq_control[`PMIC_XI_EX2],
                 irq_en_r[5:0]};
  // RULE_11: one priority bit per source
  assign prio = {extra_ext_irq_control[`PMIC_XI_PX3], extra_ext_irq_control[`PMIC_XI_PX2],
                 priority_low_reg[5:0]};
  assign cand = pend & enab & {8{irq_en_r[`PMIC_EN_GLOBAL]}};
  // RULE_14: polling order within a level
  // RULE_16: external 0 ranked first
  assign pick_hi = pmic_first(cand & prio);
  assign pick_lo = pmic_first(cand & ~prio);
  // RULE_12: strictly higher level preempts
  // RULE_13: high level served first
  assign use_hi = pick_hi[3] & ~in_srv_r[1];
  assign use_lo = ~pick_hi[3] & pick_lo[3] & (in_srv_r == 2'h0);
  assign sel_valid = use_hi | use_lo;
  assign sel_idx = use_hi ? pick_hi[2:0] : pick_lo[2:0];

  // RULE_09: enabled, global on, level mode
  // RULE_17: only external sources considered
  assign pd_wake = |(cand & {~trig[3], ~trig[2], 3'h0, ~trig[1], 1'b0, ~trig[0]});

  // ==========================================
  // Power mode machine
  always @* begin
    state_nxt = state_r;
    evt_set = 4'h0;
    case (state_r)
      ST_RUN: begin
        // RULE_06: power-down after the writing instruction
        if (instr_end_i && power_control_reg[`PMIC_PWR_DOWN]) begin
          state_nxt = ST_PD;
        // RULE_01: idle after the writing instruction
        end else if (instr_end_i && power_control_reg[`PMIC_PWR_IDLE]) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // RULE_03: any enabled request wakes
        if (cand != 8'h00) begin
          state_nxt = ST_RUN;
          evt_set[`PMIC_EVT_IDLE_WAKE] = 1'b1;
        end
      end
      ST_PD: begin
        // RULE_10: wake to run, request then served
        if (pd_wake) begin
          state_nxt = ST_RUN;
          evt_set[`PMIC_EVT_PD_WAKE] = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
    if (ack_ok) begin
      evt_set[`PMIC_EVT_VECTOR] = 1'b1;
    end
  end

  // ==========================================
  // Flags of timers and serial port
  always @* begin
    flags_nxt = flags_r;
    if (wr_i && addr_i == `PMIC_ADDR_FLAGS) begin
      flags_nxt = wdata_i[6:0];
    end
    // RULE_18: timer 0/1 cleared when vectored
    if (ack_ok && sel_idx_r == 3'h1) begin
      flags_nxt[`PMIC_FL_T0] = 1'b0;
    end
    if (ack_ok && sel_idx_r == 3'h3) begin
      flags_nxt[`PMIC_FL_T1] = 1'b0;
    end
    // Hardware set wins over any clear in the same cycle
    flags_nxt[`PMIC_FL_T0] = flags_nxt[`PMIC_FL_T0] | timer0_ovf_i;
    flags_nxt[`PMIC_FL_T1] = flags_nxt[`PMIC_FL_T1] | timer1_ovf_i;
    flags_nxt[`PMIC_FL_T2] = flags_nxt[`PMIC_FL_T2] | timer2_ovf_i;
    flags_nxt[`PMIC_FL_RX] = flags_nxt[`PMIC_FL_RX] | serial_rx_i;
    flags_nxt[`PMIC_FL_TX] = flags_nxt[`PMIC_FL_TX] | serial_tx_i;
  end

  // ==========================================
  // Main registers
  always @(posedge clk_i) begin
    cpu_reset_r <= sys_rst;
    // RULE_04: qualified pin reset also ends idle
    // RULE_05: registers return to defaults
    // RULE_07: pin reset leaves power-down to run
    if (sys_rst) begin
      state_r <= ST_RUN;
      power_control_reg <= `PMIC_RESET_BYTE;
      irq_en_r <= `PMIC_RESET_BYTE;
      priority_low_reg <= `PMIC_RESET_BYTE;
      extra_ext_irq_control <= `PMIC_RESET_BYTE;
      trig_r <= 2'h0;
      flags_r <= 7'h00;
      ext_flag_r <= 4'h0;
      ext_prev_r <= 4'hf;
      evt_en_r <= 4'h0;
      in_srv_r <= 2'h0;
      req_r <= 1'b0;
      sel_lvl_r <= 1'b0;
      sel_idx_r <= 3'h0;
      vector_r <= `PMIC_RESET_PC;
    end else begin
      state_r <= state_nxt;
      ext_prev_r <= ext_n_i;
      ext_flag_r <= ext_flag_nxt;
      flags_r <= flags_nxt;
      if (wr_i && addr_i == `PMIC_ADDR_PWR) begin
        power_control_reg <= {6'h00, wdata_i[1:0]};
      end else if (state_r == ST_IDLE && state_nxt == ST_RUN) begin
        // RULE_03: wake clears the idle bit
        power_control_reg[`PMIC_PWR_IDLE] <= 1'b0;
      end else if (state_r == ST_PD && state_nxt == ST_RUN) begin
        power_control_reg[`PMIC_PWR_DOWN] <= 1'b0;
      end
      if (wr_i && addr_i == `PMIC_ADDR_IRQ_EN) begin
        irq_en_r <= {wdata_i[7], 1'b0, wdata_i[5:0]};
      end
      if (wr_i && addr_i == `PMIC_ADDR_PRIO_LOW) begin
        priority_low_reg <= {2'h0, wdata_i[5:0]};
      end
      if (wr_i && addr_i == `PMIC_ADDR_EXT_CTRL) begin
        extra_ext_irq_control <= wdata_i;
      end
      if (wr_i && addr_i == `PMIC_ADDR_TRIG) begin
        trig_r <= wdata_i[1:0];
      end
      if (wr_i && addr_i == `PMIC_ADDR_EVT_EN) begin
        evt_en_r <= wdata_i[3:0];
      end
      // Service level stack: ack pushes, return pops the top level
      if (ack_ok) begin
        in_srv_r[sel_lvl_r] <= 1'b1;
      end else if (reti_i) begin
        if (in_srv_r[1]) begin
          in_srv_r[1] <= 1'b0;
        end else begin
          in_srv_r[0] <= 1'b0;
        end
      end
      // Request drops for a cycle after an ack so a stale choice is never re-offered
      req_r <= sel_valid & (state_nxt == ST_RUN) & ~ack_ok;
      if (!req_r || ack_ok) begin
        sel_lvl_r <= use_hi;
        sel_idx_r <= sel_idx;
        // RULE_15: vector from source index
        vector_r <= pmic_vector(sel_idx);
      end
    end
  end

  // ==========================================
  // External 2/3 flags read back in place of the stored bits
  wire [7:0] ext_ctrl_rd;
  assign ext_ctrl_rd = {extra_ext_irq_control[7:6], ext_flag_r[3], extra_ext_irq_control[4:2],
                        ext_flag_r[2], extra_ext_irq_control[0]};

  // ==========================================
  // Event status, sticky; a set wins over a clear
  always @(posedge clk_i) begin
    if (reset_i) begin
      evt_stat_r <= 4'h0;
    end else begin
      evt_stat_r <= (evt_stat_r &
                     ~((wr_i && addr_i == `PMIC_ADDR_EVT_CLR) ? wdata_i[3:0] : 4'h0)) |
                    evt_set | {1'b0, rst_valid, 2'h0};
    end
  end

  // ==========================================
  // Read port, data valid the cycle after the strobe
  always @(posedge clk_i) begin
    if (reset_i) begin
      rdata_r <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `PMIC_ADDR_PWR: rdata_r <= power_control_reg;
        `PMIC_ADDR_IRQ_EN: rdata_r <= irq_en_r;
        `PMIC_ADDR_PRIO_LOW: rdata_r <= priority_low_reg;
        `PMIC_ADDR_EXT_CTRL: rdata_r <= {ext_ctrl_rd[7:6], ext_ctrl_rd[5], ext_ctrl_rd[4:0]};
        `PMIC_ADDR_TRIG: rdata_r <= {6'h00, trig_r};
        `PMIC_ADDR_FLAGS: rdata_r <= {1'b0, flags_r[6:3], ext_flag_r[1], flags_r[1],
                                      ext_flag_r[0]};
        `PMIC_ADDR_EVT_STAT: rdata_r <= {4'h0, evt_stat_r};
        `PMIC_ADDR_EVT_EN: rdata_r <= {4'h0, evt_en_r};
        `PMIC_ADDR_STATE: rdata_r <= {sel_idx_r, in_srv_r, state_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ==========================================
  // Outputs
  assign rdata_o = rdata_r;
  assign irq_req_o = req_r;
  assign irq_vector_o = vector_r;
  // RULE_02: only CPU clock gated in idle
  assign cpu_clk_en_o = state_r[0];
  // RULE_06: every clock stopped in power-down
  assign periph_clk_en_o = ~state_r[2];
  assign ports_hold_o = ~state_r[0];
  assign cpu_reset_o = cpu_reset_r;
  // RULE_05: restart address
  assign reset_pc_o = `PMIC_RESET_PC;
  assign irq_o = |(evt_stat_r & evt_en_r);

endmodule // pmic_core

//--- test/pmic_core_props.sv
// ==========================
// Port-level checks
module pmic_core_props (
  // Clock, reset and bus
  input wire clk_i,
  input wire reset_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  // CPU side
  input wire instr_end_i,
  input wire irq_ack_i,
  input wire irq_req_o,
  input wire [15:0] irq_vector_o,
  input wire cpu_clk_en_o,
  input wire periph_clk_en_o,
  input wire ports_hold_o,
  input wire cpu_reset_o,
  input wire [15:0] reset_pc_o,
  // Reset and pins
  input wire ext_rst_i,
  input wire wdt_rst_i,
  input wire [3:0] ext_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Edges seen with the pin high, saturating
  logic [4:0] pin_run_r;
  always_ff @(posedge clk_i) begin
    if (reset_i || !ext_rst_i) begin
      pin_run_r <= 5'h00;
    end else if (pin_run_r != 5'h1f) begin
      pin_run_r <= pin_run_r + 5'h01;
    end
  end
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_pc; reset_pc_o == 16'h0000; endproperty
  a_pc: assert property (p_pc) else $error("restart address not zero");
  property p_vec; irq_req_o |-> irq_vector_o[15:6] == 10'h000 && irq_vector_o[2:0] == 3'h3;
  endproperty
  a_vec: assert property (p_vec) else $error("vector off grid");
  property p_ack; irq_req_o && irq_ack_i |=> !irq_req_o; endproperty
  a_ack: assert property (p_ack) else $error("request kept after ack");
  property p_hold; irq_req_o && !irq_ack_i && !wr_i && !ext_rst_i && !wdt_rst_i
    |=> irq_req_o && $stable(irq_vector_o); endproperty
  a_hold: assert property (p_hold) else $error("offer changed before ack");
  property p_idle; !cpu_clk_en_o |-> ports_hold_o; endproperty
  a_idle: assert property (p_idle) else $error("cpu clock off without hold");
  property p_pd; !periph_clk_en_o |-> !cpu_clk_en_o && ports_hold_o; endproperty
  a_pd: assert property (p_pd) else $error("power-down state mixed");
  property p_enter; $fell(cpu_clk_en_o) |-> $past(instr_end_i); endproperty
  a_enter: assert property (p_enter) else $error("sleep not at instruction end");
  property p_wdt; !periph_clk_en_o && wdt_rst_i && !ext_rst_i && ext_n_i == 4'hf
    |=> !periph_clk_en_o; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog ended power-down");
  property p_rlen; $rose(cpu_reset_o) && !$past(reset_i) && !$past(reset_i, 2)
    && !$past(wdt_rst_i) && !$past(wdt_rst_i, 2) |-> $past(pin_run_r) >= 5'h18; endproperty
  a_rlen: assert property (p_rlen) else $error("short pin pulse reset");
  property p_rlong; pin_run_r == 5'h1e |-> cpu_reset_o && cpu_clk_en_o && periph_clk_en_o;
  endproperty
  a_rlong: assert property (p_rlong) else $error("long pin pulse ignored");
  property p_rd; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
endmodule // pmic_core_props

bind pmic_core pmic_core_props chk_u (.clk_i(clk_i), .reset_i(reset_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .instr_end_i(instr_end_i), .irq_ack_i(irq_ack_i),
  .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o), .cpu_clk_en_o(cpu_clk_en_o),
  .periph_clk_en_o(periph_clk_en_o), .ports_hold_o(ports_hold_o),
  .cpu_reset_o(cpu_reset_o), .reset_pc_o(reset_pc_o), .ext_rst_i(ext_rst_i),
  .wdt_rst_i(wdt_rst_i), .ext_n_i(ext_n_i));

//--- test/pmic_cpu_model.sv
// ==========================
// Processor core stand-in
module pmic_cpu_model (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Core side
  input wire cpu_clk_en_i,
  input wire irq_req_i,
  input wire slow_i,
  input wire reti_en_i,
  output logic instr_end_o,
  output logic irq_ack_o,
  output logic reti_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_r;
  logic [1:0] wait_r;
  logic [3:0] depth_r;
  always @(posedge clk_i) begin
    if (reset_i) begin
      ph_r <= 2'h0;
      wait_r <= 2'h0;
      depth_r <= 4'h0;
      instr_end_o <= 1'b0;
      irq_ack_o <= 1'b0;
      reti_o <= 1'b0;
    end else begin
      // Frozen core retires nothing
      ph_r <= cpu_clk_en_i ? ph_r + 2'h1 : ph_r;
      instr_end_o <= cpu_clk_en_i && ph_r == 2'h3;
      wait_r <= irq_req_i ? wait_r + 2'h1 : 2'h0;
      irq_ack_o <= irq_req_i && !irq_ack_o && cpu_clk_en_i && (!slow_i || wait_r == 2'h2);
      // Returns only from routines it entered
      reti_o <= reti_en_i && depth_r != 4'h0 && !reti_o;
      depth_r <= depth_r + {3'h0, irq_ack_o} - {3'h0, reti_o};
    end
  end
endmodule // pmic_cpu_model

//--- test/pmic_core_tb_top.sv
`include "pmic_map.vh"

module pmic_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================
  // Wiring
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ext_rst_i = 1'b0;
  logic wdt_rst_i = 1'b0;
  logic [3:0] ext_n = 4'hf;
  logic [4:0] src = 5'h00;
  logic slow = 1'b0;
  logic reti_en = 1'b0;
  logic instr_end, irq_ack, reti, irq_req_o, cpu_clk_en_o, periph_clk_en_o, ports_hold_o, irq_o;
  logic [7:0] rdata_o;
  logic [15:0] irq_vector_o, reset_pc_o;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  always #5 clk_i = ~clk_i;
  pmic_core dut_u (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .instr_end_i(instr_end), .irq_ack_i(irq_ack),
    .reti_i(reti), .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
    .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .ports_hold_o(ports_hold_o), .cpu_reset_o(), .reset_pc_o(reset_pc_o),
    .ext_rst_i(ext_rst_i), .wdt_rst_i(wdt_rst_i), .ext_n_i(ext_n), .timer0_ovf_i(src[0]),
    .timer1_ovf_i(src[1]), .timer2_ovf_i(src[2]), .serial_rx_i(src[3]),
    .serial_tx_i(src[4]), .irq_o(irq_o));
  pmic_cpu_model cpu_u (.clk_i(clk_i), .reset_i(reset_i), .cpu_clk_en_i(cpu_clk_en_o),
    .irq_req_i(irq_req_o), .slow_i(slow), .reti_en_i(reti_en), .instr_end_o(instr_end),
    .irq_ack_o(irq_ack), .reti_o(reti));
  // ==========================
  // Helpers
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(nm, {8'h00, e}, {8'h00, rdata_o});
  endtask
  task automatic mode(input logic [2:0] e, input string nm);
    #1 chk(nm, {13'h0, e}, {13'h0, cpu_clk_en_o, periph_clk_en_o, ports_hold_o});
  endtask
  // Waits for an offer, checks its vector, lets the core take it
  task automatic wreq(input logic [15:0] v, input string nm);
    int k;
    k = 0;
    // An offer raised while the caller was still busy is only up for two cycles, four when slow is set
    #1;
    while (irq_req_o !== 1'b1 && k < 60) begin
      @(posedge clk_i);
      #1 k++;
    end
    chk(nm, v, irq_req_o ? irq_vector_o : 16'hffff);
    tick(6);
  endtask
  task automatic nreq(input string nm);
    tick(8);
    #1 chk(nm, 16'h0000, {15'h0, irq_req_o});
  endtask
  task automatic pls(input logic [4:0] m);
    @(posedge clk_i);
    src <= m;
    @(posedge clk_i);
    src <= 5'h00;
  endtask
  task automatic ret();
    @(posedge clk_i);
    reti_en <= 1'b1;
    @(posedge clk_i);
    reti_en <= 1'b0;
    tick(3);
  endtask
  // ==========================
  // Scenarios
  task automatic t_regs();
    wr(`PMIC_ADDR_STATE, 8'hff);
    rd(`PMIC_ADDR_STATE, 8'h01, "state");
    rd(`PMIC_ADDR_PWR, 8'h00, "pwr");
    rd(`PMIC_ADDR_IRQ_EN, 8'h00, "en");
    rd(`PMIC_ADDR_PRIO_LOW, 8'h00, "prio");
    rd(`PMIC_ADDR_EXT_CTRL, 8'h00, "xctl");
    rd(`PMIC_ADDR_FLAGS, 8'h00, "flags");
    rd(`PMIC_ADDR_EVT_CLR, 8'h00, "clr_wo");
    rd(4'hf, 8'h00, "unmapped");
  endtask
  task automatic t_rank();
    wr(`PMIC_ADDR_IRQ_EN, 8'hbf);
    wr(`PMIC_ADDR_EXT_CTRL, 8'h44);
    ext_n <= 4'h0;
    pls(5'h0f);
    for (int i = 0; i < 8; i++) begin
      wreq(16'h0003 + 16'(i * 8), "rank_vec");
      if (i == 3) rd(`PMIC_ADDR_FLAGS, 8'h50, "sticky");
      if (i == 3) rd(`PMIC_ADDR_EXT_CTRL, 8'h66, "xctl_ie");
      if (i == 0) ext_n[0] <= 1'b1;
      if (i == 2) ext_n[1] <= 1'b1;
      if (i == 4) wr(`PMIC_ADDR_FLAGS, 8'h40);
      if (i == 5) wr(`PMIC_ADDR_FLAGS, 8'h00);
      if (i > 5) ext_n[i - 4] <= 1'b1;
      ret();
    end
    wr(`PMIC_ADDR_EXT_CTRL, 8'h00);
  endtask
  task automatic t_prio();
    slow <= 1'b1;
    wr(`PMIC_ADDR_PRIO_LOW, 8'h08);
    wr(`PMIC_ADDR_IRQ_EN, 8'h8b);
    pls(5'h03);
    wreq(16'h001b, "hi_first");
    nreq("lo_waits");
    ret();
    wreq(16'h000b, "lo_next");
    pls(5'h02);
    wreq(16'h001b, "preempt");
    ret();
    ext_n[0] <= 1'b0;
    nreq("same_lvl");
    ret();
    wreq(16'h0003, "ext0_after");
    ext_n[0] <= 1'b1;
    ret();
    wr(`PMIC_ADDR_PRIO_LOW, 8'h00);
    slow <= 1'b0;
  endtask
  task automatic t_idle();
    wr(`PMIC_ADDR_IRQ_EN, 8'h82);
    wr(`PMIC_ADDR_PWR, 8'h01);
    tick(12);
    mode(3'h3, "idle");
    pls(5'h01);
    wreq(16'h000b, "idle_wake");
    rd(`PMIC_ADDR_PWR, 8'h00, "idle_bit");
    ret();
  endtask
  task automatic t_pd();
    wr(`PMIC_ADDR_IRQ_EN, 8'h83);
    ext_rst_i <= 1'b1;
    tick(20);
    ext_rst_i <= 1'b0;
    rd(`PMIC_ADDR_IRQ_EN, 8'h83, "short_rst");
    wr(`PMIC_ADDR_TRIG, 8'h01);
    wr(`PMIC_ADDR_PWR, 8'h02);
    tick(8);
    pls(5'h01);
    wdt_rst_i <= 1'b1;
    tick(3);
    wdt_rst_i <= 1'b0;
    ext_n[0] <= 1'b0;
    tick(3);
    ext_n[0] <= 1'b1;
    tick(3);
    mode(3'h1, "pd_stay");
    @(posedge clk_i);
    ext_rst_i <= 1'b1;
    tick(30);
    ext_rst_i <= 1'b0;
    tick(3);
    mode(3'h6, "pd_rst");
    rd(`PMIC_ADDR_IRQ_EN, 8'h00, "rst_clear");
    wr(`PMIC_ADDR_IRQ_EN, 8'h81);
    wr(`PMIC_ADDR_PWR, 8'h02);
    tick(8);
    mode(3'h1, "pd2");
    @(posedge clk_i);
    ext_n[0] <= 1'b0;
    wreq(16'h0003, "pd_wake");
    ext_n[0] <= 1'b1;
    ret();
    rd(`PMIC_ADDR_PWR, 8'h00, "pd_bit");
    rd(`PMIC_ADDR_EVT_STAT, 8'h0f, "evt_all");
  endtask
  task automatic t_evt();
    slow <= 1'b1;
    wr(`PMIC_ADDR_EVT_CLR, 8'h0f);
    wr(`PMIC_ADDR_IRQ_EN, 8'h82);
    pls(5'h01);
    wreq(16'h000b, "evt_vec");
    rd(`PMIC_ADDR_EVT_STAT, 8'h08, "evt_stat");
    chk("irq_masked", 16'h0000, {15'h0, irq_o});
    wr(`PMIC_ADDR_EVT_EN, 8'h08);
    #1 chk("irq_on", 16'h0001, {15'h0, irq_o});
    wr(`PMIC_ADDR_EVT_CLR, 8'h08);
    #1 chk("irq_off", 16'h0000, {15'h0, irq_o});
    ret();
  endtask
  initial begin
    tick(5);
    reset_i <= 1'b0;
    t_regs();
    $display("test regs done");
    t_rank();
    $display("test rank done");
    t_prio();
    $display("test prio done");
    t_idle();
    $display("test idle done");
    t_pd();
    $display("test power_down done");
    t_evt();
    $display("test events done");
    end_of_test();
  end
endmodule // pmic_core_tb_top
